// file: src/pll_operational_control_regs.sv
// Register bank for loop operational controls: loop zero mode, resets,
// phase stepping, and channel one sync, calibration and deep sleep.
// Assumes a same-clock host port; read data appear one cycle after the strobe.
//
// Contract
// [RULE_01] Bits 6:5 pick reference A to D
// [RULE_02] Bits 4:2 set switchover mode 000-010
// [RULE_03] Mode 011 falls back to holdover
// [RULE_04] Mode 100 no fallback; 101-111 unused
// [RULE_05] User-mode bit 1 forces holdover
// [RULE_06] User-mode bit 0 forces free run
// [RULE_07] Reset bit 2 clears loop filter
// [RULE_08] Reset bit 1 resets tuning-word history
// [RULE_09] Reset bit 0 resets autosync logic
// [RULE_10] Phase bit 2 zeroes offset, self-clears
// [RULE_11] Phase bit 1 subtracts step, self-clears
// [RULE_12] Phase bit 0 adds step, self-clears
// [RULE_13] Sync bit 2 stalls; restart on fall
// [RULE_14] Calibration starts on bit 1 rise
// [RULE_15] Sync bit 0 puts channel asleep
// [RULE_16] Zero command beats increment and decrement
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module pll_operational_control_regs
  import loop_ctrl_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [STEP_W-1:0] step_size,
  input  wire logic              ref_fail,
  output logic      [DATA_W-1:0] rd_data,
  output logic      [1:0]        ref_select,
  output logic      [2:0]        switch_mode,
  output logic      [1:0]        op_state,
  output logic                   loop_filter_clear,
  output logic                   tw_history_reset,
  output logic                   autosync_reset,
  output logic      [PHASE_W-1:0] phase_offset,
  output logic                   dist_stall,
  output logic                   dist_restart,
  output logic                   cal_start,
  output logic                   chan1_sleep
);
  typedef struct packed {
    logic [7:0]  user_mode;
    logic [7:0]  reset_ctrl;
    logic [7:0]  sync_cal;
    logic [7:0]  rd_data;
    logic [1:0]  op_state;
    logic        filt_clr;
    logic        tw_rst;
    logic        as_rst;
    logic        restart;
    logic        cal_start;
  } regs_state_t;

  regs_state_t st_q;
  regs_state_t st_d;

  logic        wr_user;
  logic        wr_reset;
  logic        wr_phase;
  logic        wr_sync;
  logic        cmd_zero;
  logic        cmd_dec;
  logic        cmd_inc;
  logic        soft_fall;
  logic        cal_rise;
  logic [2:0]  mode_f;
  logic [PHASE_W-1:0] acc_offset;
  logic [PHASE_W-1:0] step_wide;

  // Write decode; the phase register is write-one-to-act only
  assign wr_user  = wr_en && (addr == LOOP0_USER_MODE_ADDR);
  assign wr_reset = wr_en && (addr == LOOP0_RESET_CONTROLS_ADDR);
  assign wr_phase = wr_en && (addr == LOOP0_PHASE_STEP_ADDR);
  assign wr_sync  = wr_en && (addr == CHAN1_SYNC_CALIBRATE_ADDR);

  // [RULE_16] zero takes priority
  assign cmd_zero = wr_phase && wr_data[PHASE_ZERO_BIT];
  // [RULE_11] decrement pulse
  assign cmd_dec  = wr_phase && wr_data[PHASE_DEC_BIT] && !cmd_zero;
  // [RULE_12] increment pulse
  assign cmd_inc  = wr_phase && wr_data[PHASE_INC_BIT] && !cmd_zero;

  assign mode_f = st_q.user_mode[SWITCH_MODE_HI:SWITCH_MODE_LO];
  // Step widened once so the phase checks add at full accumulator width
  assign step_wide = {{(PHASE_W-STEP_W){1'b0}}, step_size};

  // [RULE_10] accumulator zeroes and steps
  phase_offset_acc u_acc
  (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .cmd_zero     (cmd_zero),
    .cmd_dec      (cmd_dec),
    .cmd_inc      (cmd_inc),
    .step_size    (step_size),
    .phase_offset (acc_offset)
  );

  edge_pulse u_sync_edge
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .level   (st_q.sync_cal[SOFT_SYNC_BIT]),
    .rise    (),
    .fall    (soft_fall)
  );

  edge_pulse u_cal_edge
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .level   (st_q.sync_cal[CALIBRATE_BIT]),
    .rise    (cal_rise),
    .fall    ()
  );

  // Readback mux; unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [11:0] a, input regs_state_t s,
                                         input logic [PHASE_W-1:0] p);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      LOOP0_USER_MODE_ADDR:          r = s.user_mode;
      LOOP0_RESET_CONTROLS_ADDR:     r = s.reset_ctrl;
      LOOP0_PHASE_STEP_ADDR:         r = 8'h00;
      CHAN1_SYNC_CALIBRATE_ADDR:     r = s.sync_cal;
      PHASE_OFFSET_BASE_ADDR:        r = p[7:0];
      PHASE_OFFSET_BASE_ADDR + 12'h1: r = p[15:8];
      PHASE_OFFSET_BASE_ADDR + 12'h2: r = p[23:16];
      PHASE_OFFSET_BASE_ADDR + 12'h3: r = p[31:24];
      default:                       r = 8'h00;
    endcase
    read_mux = r;
  endfunction

  // Next state: register writes, derived controls and readback
  always_comb
  begin
    st_d = st_q;
    if (wr_user)
    begin
      st_d.user_mode = masked(wr_data, USER_MODE_MASK);
    end
    if (wr_reset)
    begin
      st_d.reset_ctrl = masked(wr_data, RESET_CTRL_MASK);
    end
    if (wr_sync)
    begin
      st_d.sync_cal = masked(wr_data, SYNC_CAL_MASK);
    end
    // [RULE_07] loop filter held clear
    st_d.filt_clr = st_d.reset_ctrl[RST_LOOP_FILTER_BIT];
    // [RULE_08] history reset level
    st_d.tw_rst = st_d.reset_ctrl[RST_TW_HISTORY_BIT];
    // [RULE_09] autosync reset level
    st_d.as_rst = st_d.reset_ctrl[RST_AUTOSYNC_BIT];
    // [RULE_13] restart pulse on falling sync bit
    st_d.restart = soft_fall;
    // [RULE_14] calibration on rising bit only
    st_d.cal_start = cal_rise;
    // Free run wins over holdover; a failed manual ref holds over in mode 011
    // [RULE_06] forced free run
    if (st_d.user_mode[USER_FREE_RUN_BIT])
    begin
      st_d.op_state = OP_FREE_RUN;
    end
    // [RULE_05] forced holdover
    else if (st_d.user_mode[USER_HOLDOVER_BIT])
    begin
      st_d.op_state = OP_HOLDOVER;
    end
    // [RULE_03] holdover on manual ref failure
    else if (mode_f == MODE_MANUAL_HOLD && ref_fail)
    begin
      st_d.op_state = OP_HOLDOVER;
    end
    else
    begin
      st_d.op_state = OP_NORMAL;
    end
    st_d.rd_data = rd_en ? read_mux(addr, st_q, acc_offset) : 8'h00;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign rd_data           = st_q.rd_data;
  // [RULE_01] reference select field
  assign ref_select        = st_q.user_mode[MANUAL_REF_HI:MANUAL_REF_LO];
  // [RULE_02] switchover mode field; unused codes pass through untouched
  // [RULE_04] core treats 100 as manual only
  assign switch_mode       = mode_f;
  assign op_state          = st_q.op_state;
  assign loop_filter_clear = st_q.filt_clr;
  assign tw_history_reset  = st_q.tw_rst;
  assign autosync_reset    = st_q.as_rst;
  assign phase_offset      = acc_offset;
  // [RULE_13] stall while bit set
  assign dist_stall        = st_q.sync_cal[SOFT_SYNC_BIT];
  assign dist_restart      = st_q.restart;
  assign cal_start         = st_q.cal_start;
  // [RULE_15] deep sleep control
  assign chan1_sleep       = st_q.sync_cal[DEEP_SLEEP_BIT];

  // Assertions
  a_free_run_force: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_06]
    st_q.user_mode[USER_FREE_RUN_BIT] |-> op_state == OP_FREE_RUN)
    else $error("free run not forced");
  a_holdover_force: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_05]
    (st_q.user_mode[USER_HOLDOVER_BIT] && !st_q.user_mode[USER_FREE_RUN_BIT])
      |-> op_state == OP_HOLDOVER)
    else $error("holdover not forced");
  a_mode3_fallback: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_03]
    (st_q.user_mode[USER_HOLDOVER_BIT:USER_FREE_RUN_BIT] == 2'h0 && mode_f == MODE_MANUAL_HOLD
      && ref_fail)
      |=> (op_state == OP_HOLDOVER || $changed(st_q.user_mode)))
    else $error("no holdover on manual ref fail");
  a_zero_phase: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_10]
    (wr_en && addr == LOOP0_PHASE_STEP_ADDR && wr_data[PHASE_ZERO_BIT])
      |=> phase_offset == PHASE_ZERO)
    else $error("phase not zeroed");
  a_inc_phase: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_12]
    (cmd_inc && !cmd_dec) |=> phase_offset == $past(acc_offset) + $past(step_wide))
    else $error("phase increment wrong");
  a_dec_phase: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_11]
    (cmd_dec && !cmd_inc) |=> phase_offset == $past(acc_offset) - $past(step_wide))
    else $error("phase decrement wrong");
  a_zero_priority: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_16]
    (wr_phase && wr_data[PHASE_ZERO_BIT] && (wr_data[PHASE_INC_BIT] || wr_data[PHASE_DEC_BIT]))
      |=> phase_offset == PHASE_ZERO)
    else $error("zero lost priority");
  sequence s_cal_rise;
    wr_sync && wr_data[CALIBRATE_BIT] && !st_q.sync_cal[CALIBRATE_BIT];
  endsequence
  a_cal_edge: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_14]
    s_cal_rise |=> ##1 cal_start ##1 !cal_start)
    else $error("calibration pulse wrong");
  a_sync_restart: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_13]
    $fell(dist_stall) |=> dist_restart)
    else $error("no restart after sync");
  a_sleep_write: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_15]
    wr_sync |=> chan1_sleep == $past(wr_data[DEEP_SLEEP_BIT]))
    else $error("sleep bit not stored");
  a_filter_clear: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_07]
    wr_reset |=> loop_filter_clear == $past(wr_data[RST_LOOP_FILTER_BIT]))
    else $error("filter clear wrong");
  a_ref_select: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
    wr_user |=> ref_select == $past(wr_data[MANUAL_REF_HI:MANUAL_REF_LO]))
    else $error("reference select wrong");

  // Field copies, visible one edge after the write, back to back too
  a_switch_mode: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_02]
    wr_user |=> switch_mode == $past(wr_data[SWITCH_MODE_HI:SWITCH_MODE_LO]))
    else $error("switchover mode wrong");
  // Mode 100 keeps the loop running on a failed reference
  a_manual_only: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_04]
    (mode_f == MODE_MANUAL_ONLY && ref_fail && !wr_user
      && st_q.user_mode[USER_HOLDOVER_BIT:USER_FREE_RUN_BIT] == 2'h0)
      |=> op_state == OP_NORMAL)
    else $error("mode 100 fell back");
  a_history_reset: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
    wr_reset |=> tw_history_reset == $past(wr_data[RST_TW_HISTORY_BIT]))
    else $error("history reset wrong");
  a_autosync_reset: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_09]
    wr_reset |=> autosync_reset == $past(wr_data[RST_AUTOSYNC_BIT]))
    else $error("autosync reset wrong");
  a_stall_level: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_13]
    wr_sync |=> dist_stall == $past(wr_data[SOFT_SYNC_BIT]))
    else $error("stall bit not stored");
  // A pulse with no edge behind it would rerun calibration or restart outputs
  a_cal_only_edge: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_14]
    cal_start |-> $past(st_q.sync_cal[CALIBRATE_BIT]) && !$past(st_q.sync_cal[CALIBRATE_BIT], 2))
    else $error("calibration without rising bit");
  a_restart_only_fall: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_13]
    dist_restart |-> $past(dist_stall, 2) && !$past(dist_stall))
    else $error("restart without falling bit");
  // Read data stand one cycle only, so a late sampler sees zero
  a_read_window: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside window");
  a_phase_bytes: assert property (@(posedge ref_clk) disable iff (reset)
    (rd_en && addr == PHASE_OFFSET_BASE_ADDR) |=> rd_data == $past(acc_offset[DATA_W-1:0]))
    else $error("phase byte read wrong");
  a_phase_write_only: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_10]
    (rd_en && addr == LOOP0_PHASE_STEP_ADDR) |=> rd_data == 8'h00)
    else $error("phase register read not zero");
endmodule

// file: src/loop_ctrl_pkg.sv
// Package for the loop operational control register bank.
// Assumes byte-wide registers on a plain address/strobe port.
package loop_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PHASE_W = 32;
  localparam int STEP_W = 16;

  // Register offsets
  localparam logic [11:0] LOOP0_USER_MODE_ADDR      = 12'hA22;
  localparam logic [11:0] LOOP0_RESET_CONTROLS_ADDR = 12'hA23;
  localparam logic [11:0] LOOP0_PHASE_STEP_ADDR     = 12'hA24;
  localparam logic [11:0] CHAN1_SYNC_CALIBRATE_ADDR = 12'hA40;
  // Phase offset readback, four bytes from this base
  localparam logic [11:0] PHASE_OFFSET_BASE_ADDR    = 12'hA28;

  // User-mode fields
  localparam int MANUAL_REF_HI = 6;
  localparam int MANUAL_REF_LO = 5;
  localparam int SWITCH_MODE_HI = 4;
  localparam int SWITCH_MODE_LO = 2;
  localparam int USER_HOLDOVER_BIT = 1;
  localparam int USER_FREE_RUN_BIT = 0;
  localparam logic [7:0] USER_MODE_MASK = 8'h7F;

  // Reset-control fields
  localparam int RST_LOOP_FILTER_BIT = 2;
  localparam int RST_TW_HISTORY_BIT  = 1;
  localparam int RST_AUTOSYNC_BIT    = 0;
  localparam logic [7:0] RESET_CTRL_MASK = 8'h07;

  // Phase command fields
  localparam int PHASE_ZERO_BIT = 2;
  localparam int PHASE_DEC_BIT  = 1;
  localparam int PHASE_INC_BIT  = 0;

  // Sync/calibrate fields
  localparam int SOFT_SYNC_BIT    = 2;
  localparam int CALIBRATE_BIT    = 1;
  localparam int DEEP_SLEEP_BIT   = 0;
  localparam logic [7:0] SYNC_CAL_MASK = 8'h07;

  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 32'h0000_0000;

  // Reference selection and switchover modes
  typedef enum logic [1:0] {
    REF_A = 2'h0,
    REF_B = 2'h1,
    REF_C = 2'h2,
    REF_D = 2'h3
  } ref_sel_t;

  typedef enum logic [2:0] {
    MODE_AUTO_REVERT    = 3'h0,
    MODE_AUTO_NONREVERT = 3'h1,
    MODE_MANUAL_FALLREF = 3'h2,
    MODE_MANUAL_HOLD    = 3'h3,
    MODE_MANUAL_ONLY    = 3'h4
  } switch_mode_t;

  // Loop operating state presented to the loop core
  typedef enum logic [1:0] {
    OP_NORMAL   = 2'h0,
    OP_HOLDOVER = 2'h1,
    OP_FREE_RUN = 2'h3
  } op_state_t;

  // Mask a byte by a field mask; used for the user-mode, reset-control and sync/calibrate writes
  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction
endpackage

// file: src/phase_offset_acc.sv
// Incremental phase offset accumulator for loop zero.
// Assumes one-cycle command pulses; zero beats step when both arrive.
`timescale 1ns/1ps
module phase_offset_acc
  import loop_ctrl_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               cmd_zero,
  input  wire logic               cmd_dec,
  input  wire logic               cmd_inc,
  input  wire logic [STEP_W-1:0]  step_size,
  output logic      [PHASE_W-1:0] phase_offset
);
  typedef struct packed {
    logic [PHASE_W-1:0] offset;
  } acc_state_t;

  acc_state_t st_q;
  acc_state_t st_d;
  logic [PHASE_W-1:0] step_ext;

  assign step_ext = {{(PHASE_W-STEP_W){1'b0}}, step_size};

  // Zero first, then a net step; inc and dec together cancel
  always_comb
  begin
    st_d = st_q;
    if (cmd_zero)
    begin
      st_d.offset = PHASE_ZERO;
    end
    else if (cmd_inc && !cmd_dec)
    begin
      st_d.offset = st_q.offset + step_ext;
    end
    else if (cmd_dec && !cmd_inc)
    begin
      st_d.offset = st_q.offset - step_ext;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign phase_offset = st_q.offset;
endmodule

// file: src/edge_pulse.sv
// Rising and falling edge detector for register bits on ref_clk.
// Input comes from same-clock logic, so no synchroniser is needed.
`timescale 1ns/1ps
module edge_pulse
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t st_q;
  edge_state_t st_d;

  // Previous level kept one cycle
  always_comb
  begin
    st_d.prev = level;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rise = level & ~st_q.prev;
  assign fall = ~level & st_q.prev;
endmodule

// file: verif/testbench.sv
// Self-checking bench for the loop operational control register bank.
// Assumes one clock, reads answered the cycle after the strobe, no waits.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
  import loop_ctrl_pkg::*;
;
  logic               ref_clk  = 1'b0;
  logic               reset    = 1'b1;
  logic [ADDR_W-1:0]  addr     = '0;
  logic [DATA_W-1:0]  wr_data  = '0;
  logic               wr_en    = 1'b0;
  logic               rd_en    = 1'b0;
  logic [STEP_W-1:0]  step_size = '0;
  logic               ref_fail = 1'b0;
  logic [DATA_W-1:0]  rd_data;
  logic [1:0]         ref_select;
  logic [2:0]         switch_mode;
  logic [1:0]         op_state;
  logic               loop_filter_clear;
  logic               tw_history_reset;
  logic               autosync_reset;
  logic [PHASE_W-1:0] phase_offset;
  logic               dist_stall;
  logic               dist_restart;
  logic               cal_start;
  logic               chan1_sleep;
  int                 fail_count = 0;
  int                 compares   = 0;
  int                 cal_n      = 0;
  int                 restart_cnt = 0;

  pll_operational_control_regs i_dut (
    .ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .step_size(step_size), .ref_fail(ref_fail), .rd_data(rd_data),
    .ref_select(ref_select), .switch_mode(switch_mode), .op_state(op_state),
    .loop_filter_clear(loop_filter_clear), .tw_history_reset(tw_history_reset),
    .autosync_reset(autosync_reset), .phase_offset(phase_offset),
    .dist_stall(dist_stall), .dist_restart(dist_restart), .cal_start(cal_start),
    .chan1_sleep(chan1_sleep)
  );

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Pulse tallies; a count, not a snapshot, so a doubled pulse is caught too
  always @(posedge ref_clk)
  begin
    if (cal_start === 1'b1) cal_n <= cal_n + 1;
    if (dist_restart === 1'b1) restart_cnt <= restart_cnt + 1;
  end

  task automatic give_verdict;
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One-cycle write strobe, changed only right after an edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  // One-cycle read strobe; data looked at only in the following cycle
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, e);
  endtask

  // Outputs are registered two deep at most, so three edges is plenty
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Everything idle and zero straight out of reset, unmapped reads zero
  task automatic t_reset;
    `CHK({ref_select, switch_mode, op_state, dist_stall, chan1_sleep}, 9'h000);
    `CHK({loop_filter_clear, tw_history_reset, autosync_reset}, 3'h0);
    `CHK(phase_offset, PHASE_ZERO);
    rd_chk(LOOP0_USER_MODE_ADDR, 8'h00);
    rd_chk(LOOP0_RESET_CONTROLS_ADDR, 8'h00);
    rd_chk(CHAN1_SYNC_CALIBRATE_ADDR, 8'h00);
    rd_chk(12'hA25, 8'h00);
  endtask

  // Every reference against every defined mode; bit 7 must not stick
  task automatic t_user_mode;
    for (int r = 0; r < 4; r++)
      for (int m = 0; m < 5; m++)
      begin
        wr(LOOP0_USER_MODE_ADDR, {1'b1, 2'(r), 3'(m), 2'b00});
        settle();
        `CHK(ref_select, 2'(r));
        `CHK(switch_mode, 3'(m));
        rd_chk(LOOP0_USER_MODE_ADDR, {1'b0, 2'(r), 3'(m), 2'b00});
      end
  endtask

  task automatic op_case(input logic [7:0] d, input logic f, input logic [1:0] e);
    @(posedge ref_clk);
    ref_fail <= f;
    wr(LOOP0_USER_MODE_ADDR, d);
    settle();
    `CHK(op_state, e);
  endtask

  // Forced modes and the holdover fallback of mode 011
  task automatic t_op_state;
    op_case(8'h0C, 1'b1, OP_HOLDOVER);
    op_case(8'h0C, 1'b0, OP_NORMAL);
    op_case(8'h10, 1'b1, OP_NORMAL);
    op_case(8'h02, 1'b0, OP_HOLDOVER);
    op_case(8'h01, 1'b0, OP_FREE_RUN);
    op_case(8'h03, 1'b0, OP_FREE_RUN);
    op_case(8'h00, 1'b0, OP_NORMAL);
  endtask

  // Each reset bit alone, reserved bits set alongside and ignored
  task automatic t_reset_ctl;
    for (int b = 0; b < 3; b++)
    begin
      wr(LOOP0_RESET_CONTROLS_ADDR, 8'hF8 | 8'(1 << b));
      settle();
      `CHK({loop_filter_clear, tw_history_reset, autosync_reset}, 3'(1 << b));
      rd_chk(LOOP0_RESET_CONTROLS_ADDR, 8'(1 << b));
    end
    wr(LOOP0_RESET_CONTROLS_ADDR, 8'h00);
    settle();
    `CHK({loop_filter_clear, tw_history_reset, autosync_reset}, 3'h0);
  endtask

  task automatic ph_case(input logic [7:0] d, input logic [PHASE_W-1:0] e);
    wr(LOOP0_PHASE_STEP_ADDR, d);
    settle();
    `CHK(phase_offset, e);
  endtask

  // Stepping; a bit that failed to self-clear would keep stepping in settle
  task automatic t_phase;
    @(posedge ref_clk);
    step_size <= 16'h0010;
    ph_case(8'h01, 32'h0000_0010);
    ph_case(8'h01, 32'h0000_0020);
    rd_chk(LOOP0_PHASE_STEP_ADDR, 8'h00);
    ph_case(8'h02, 32'h0000_0010);
    @(posedge ref_clk);
    step_size <= 16'hFFFF;
    ph_case(8'h02, 32'hFFFF_0011);
    rd_chk(PHASE_OFFSET_BASE_ADDR, 8'h11);
    rd_chk(PHASE_OFFSET_BASE_ADDR + 12'h003, 8'hFF);
    ph_case(8'h07, PHASE_ZERO);
    ph_case(8'h01, 32'h0000_FFFF);
    ph_case(8'h04, PHASE_ZERO);
  endtask

  task automatic sy_case(input logic [7:0] d, input int nr, input int nc);
    wr(CHAN1_SYNC_CALIBRATE_ADDR, d);
    settle();
    `CHK({dist_stall, chan1_sleep}, {d[SOFT_SYNC_BIT], d[DEEP_SLEEP_BIT]});
    `CHK(restart_cnt, nr);
    `CHK(cal_n, nc);
  endtask

  // Stall and restart, edge-only calibration, sleep level
  task automatic t_sync;
    sy_case(8'h04, 0, 0);
    rd_chk(CHAN1_SYNC_CALIBRATE_ADDR, 8'h04);
    sy_case(8'h00, 1, 0);
    sy_case(8'h02, 1, 1);
    sy_case(8'h02, 1, 1);
    sy_case(8'h03, 1, 1);
    rd_chk(CHAN1_SYNC_CALIBRATE_ADDR, 8'h03);
    sy_case(8'hF8, 1, 1);
    rd_chk(CHAN1_SYNC_CALIBRATE_ADDR, 8'h00);
    sy_case(8'h02, 1, 2);
  endtask

  // Reset in mid-run clears every register and the accumulator, with no
  // stray restart or calibration pulse from the bits it drops
  task automatic t_mid_reset;
    wr(LOOP0_USER_MODE_ADDR, 8'h63);
    wr(CHAN1_SYNC_CALIBRATE_ADDR, 8'h07);
    ph_case(8'h01, 32'h0000_FFFF);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    settle();
    `CHK({ref_select, switch_mode, op_state, dist_stall, chan1_sleep}, 9'h000);
    `CHK(phase_offset, PHASE_ZERO);
    `CHK(restart_cnt, 1);
    `CHK(cal_n, 2);
  endtask

  // Main sequence: three cycles of reset, then each scenario in turn
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_user_mode();
    t_op_state();
    t_reset_ctl();
    t_phase();
    t_sync();
    t_mid_reset();
    give_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #50000;
    fail_count++;
    give_verdict();
  end
endmodule
